//--- rfb_bank_map.sv
// Maps a visible register index to a physical storage slot by mode.
// Assumes the mode code is checked for legality elsewhere.
`timescale 1ns/10ps
`default_nettype none
module rfb_bank_map (
  // Lookup
  input  wire logic [4:0] mode_in,
  input  wire logic [3:0] idx_in,
  // Result
  output logic      [4:0] slot_out
);
  import rfb_pkg::*;

  // Private banks override shared slots; system falls through to user
  always_comb begin
    slot_out = {1'b0, idx_in};
    if (mode_in == RFB_MODE_FIQ && idx_in >= RFB_IDX_HI && idx_in <= RFB_IDX_LR) begin
      slot_out = RFB_SLOT_FIQ + {1'b0, idx_in - RFB_IDX_HI};
    end else if (idx_in == RFB_IDX_SP || idx_in == RFB_IDX_LR) begin
      if (mode_in == RFB_MODE_SVC) begin
        slot_out = RFB_SLOT_SVC + {4'h0, idx_in[0] ^ 1'b1};
      end else if (mode_in == RFB_MODE_IRQ) begin
        slot_out = RFB_SLOT_IRQ + {4'h0, idx_in[0] ^ 1'b1};
      end else if (mode_in == RFB_MODE_UND) begin
        slot_out = RFB_SLOT_UND + {4'h0, idx_in[0] ^ 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

//--- rfb_cond.sv
// Condition evaluation from the four status flags.
// Assumes flags come straight from the current status register.
`timescale 1ns/10ps
`default_nettype none
module rfb_cond (
  // Condition and state
  input  wire logic [3:0] cond_in,
  input  wire logic [3:0] nzcv_in,
  input  wire logic       compact_in,
  input  wire logic       is_branch_in,
  // Verdict
  output logic            pass_out
);
  logic n, z, c, v, hit;
  assign {n, z, c, v} = nzcv_in;

  // Standard condition table; code 1111 passes only for compact non-branches
  always_comb begin
    case (cond_in[3:1])
      3'h0: hit = z;
      3'h1: hit = c;
      3'h2: hit = n;
      3'h3: hit = v;
      3'h4: hit = c & ~z;
      3'h5: hit = (n == v);
      3'h6: hit = ~z & (n == v);
      default: hit = 1'b1;
    endcase
  end

  // Compact state: only branches are conditional
  assign pass_out = (compact_in && !is_branch_in) ? 1'b1 :
                    (cond_in == 4'hF) ? 1'b0 : (cond_in[0] && cond_in != 4'hE) ? ~hit : hit;
endmodule
`default_nettype wire

//--- rfb_core.sv
// Core-side partner: one strobe at a time on the operand, write, link and status ports.
// Assumes the bench calls pulse from a single process; strobes last one cycle.
`timescale 1ns/10ps
`default_nettype none
module rfb_core (
  // Clock
  input  wire logic        clk_in,
  // Strobes and payload
  output logic [3:0]  ri_out = '0,
  output logic        rh_out = 1'b0,
  output logic        mk_out = 1'b0,
  output logic        we_out = 1'b0,
  output logic [3:0]  wi_out = '0,
  output logic [31:0] wd_out = '0,
  output logic        bl_out = 1'b0,
  output logic        xe_out = 1'b0,
  output logic [4:0]  xm_out = '0,
  output logic [31:0] xl_out = '0,
  output logic        xr_out = 1'b0,
  output logic        pe_out = 1'b0,
  output logic [31:0] pd_out = '0,
  output logic        fe_out = 1'b0,
  output logic [3:0]  fn_out = '0
);
  // One kind of request per call; kind selects which strobe rises
  task automatic pulse(input int k, input logic [3:0] i, input logic [31:0] d, input logic [4:0] m);
    @(posedge clk_in);
    case (k)
      0: begin ri_out <= i; rh_out <= m[0]; mk_out <= 1'b1; end
      1: begin we_out <= 1'b1; wi_out <= i; wd_out <= d; rh_out <= m[0]; end
      2: bl_out <= 1'b1;
      3: begin xe_out <= 1'b1; xm_out <= m; xl_out <= d; end
      4: xr_out <= 1'b1;
      5: begin pe_out <= 1'b1; pd_out <= d; end
      default: begin fe_out <= 1'b1; fn_out <= i; end
    endcase
    @(posedge clk_in);
    {mk_out, we_out, bl_out, xe_out, xr_out, pe_out, fe_out} <= 7'h00;
    // Stale payload is inverted so nothing relies on it after the strobe
    {wd_out, xl_out, pd_out} <= ~{wd_out, xl_out, pd_out};
  endtask
endmodule
`default_nettype wire

//--- rfb_pkg.sv
// Constants, mode codes and helpers for the banked register file.
// Assumes a single clock domain; no other files needed.
`default_nettype none
package rfb_pkg;
  // Data width and storage layout
  localparam int RFB_XLEN = 32;
  localparam int RFB_NSLOT = 29;
  localparam logic [4:0] RFB_SLOT_FIQ = 5'h10;   // Fast bank regs 8..14
  localparam logic [4:0] RFB_SLOT_SVC = 5'h17;   // Supervisor stack/link
  localparam logic [4:0] RFB_SLOT_IRQ = 5'h19;   // Normal interrupt stack/link
  localparam logic [4:0] RFB_SLOT_UND = 5'h1B;   // Undefined stack/link
  localparam logic [3:0] RFB_IDX_SP = 4'hD;
  localparam logic [3:0] RFB_IDX_LR = 4'hE;
  localparam logic [3:0] RFB_IDX_PC = 4'hF;
  localparam logic [3:0] RFB_IDX_HI = 4'h8;      // First upper register
  // Mode codes
  localparam logic [4:0] RFB_MODE_USR = 5'h10;
  localparam logic [4:0] RFB_MODE_FIQ = 5'h11;
  localparam logic [4:0] RFB_MODE_IRQ = 5'h12;
  localparam logic [4:0] RFB_MODE_SVC = 5'h13;
  localparam logic [4:0] RFB_MODE_UND = 5'h1B;
  localparam logic [4:0] RFB_MODE_SYS = 5'h1F;
  // Status register fields
  localparam int RFB_PSR_N = 31;
  localparam int RFB_PSR_V = 28;
  localparam int RFB_PSR_I = 7;
  localparam int RFB_PSR_F = 6;
  localparam int RFB_PSR_T = 5;
  localparam logic [31:0] RFB_PSR_RESET = 32'h000000D3;
  localparam logic [31:0] RFB_LINK_OFS_WIDE = 32'h00000004;
  localparam logic [31:0] RFB_LINK_OFS_CMP = 32'h00000002;
  // Bus register offsets and responses
  localparam logic [7:0] RFB_OFS_SEL = 8'h00;
  localparam logic [7:0] RFB_OFS_DATA = 8'h04;
  localparam logic [7:0] RFB_OFS_PSR = 8'h08;
  localparam logic [7:0] RFB_OFS_SAVED = 8'h0C;
  localparam logic [1:0] RFB_RESP_OK = 2'h0;
  localparam logic [1:0] RFB_RESP_ERR = 2'h2;

  function automatic logic rfb_legal(input logic [4:0] m);
    return m == RFB_MODE_USR || m == RFB_MODE_FIQ || m == RFB_MODE_IRQ ||
           m == RFB_MODE_SVC || m == RFB_MODE_UND || m == RFB_MODE_SYS;
  endfunction

  function automatic logic rfb_has_saved(input logic [4:0] m);
    return m == RFB_MODE_FIQ || m == RFB_MODE_IRQ || m == RFB_MODE_SVC || m == RFB_MODE_UND;
  endfunction

  function automatic logic [1:0] rfb_saved_idx(input logic [4:0] m);
    return (m == RFB_MODE_FIQ) ? 2'h0 : (m == RFB_MODE_SVC) ? 2'h1 : (m == RFB_MODE_IRQ) ? 2'h2 : 2'h3;
  endfunction
endpackage
`default_nettype wire

//--- rfb_regfile.sv
// Banked general and status register file with an AXI4-Lite debug view.
// Assumes the core datapath drives all ports on ref_clk_in, same reset.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Wide state shows sixteen registers plus current and maybe saved status.
// - Privileged modes swap in their private banked registers.
// - Index 15 is the program counter; lower indices are general.
// - Wide state program counter keeps bits 1 and 0 zero.
// - Compact state program counter keeps bit 0 zero.
// - Branch-with-link copies the program counter into index 14; the code writes pc plus 4, or plus 2 in compact state.
// - Exception entry writes the return value into the target mode link.
// - Fast mode has seven private registers for indices 8 to 14.
// - Supervisor, normal and undefined modes own private indices 13 and 14.
// - Compact state reaches only indices 0-7, pc, stack, link, status.
// - Indices 0-7 are one storage for both states.
// - Compact stack, link, pc map to wide 13, 14, 15 with banks.
// - Status registers are shared by both states.
// - Compact upper moves may reach indices 8 to 15.
// - Compact compare and add may read upper registers.
// - One current and four saved status registers.
// - Status holds flags, interrupt disables and the mode.
// - Current status holds the flags and mode bits.
// - Flags update from arithmetic and feed condition checks.
// - All wide instructions conditional; only compact branches conditional.
// - Mode field selects banking; unlisted codes are illegal.
// - Low eight bits change on exception; software writes need privilege.
// - Exception entry saves current status into the target saved status.
module rfb_regfile #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]    axi_awaddr_in,
  input  wire logic                 axi_awvalid_in,
  output logic                      axi_awready_out,
  input  wire logic [31:0]          axi_wdata_in,
  input  wire logic [3:0]           axi_wstrb_in,
  input  wire logic                 axi_wvalid_in,
  output logic                      axi_wready_out,
  output logic [1:0]                axi_bresp_out,
  output logic                      axi_bvalid_out,
  input  wire logic                 axi_bready_in,
  input  wire logic [ADDR_W-1:0]    axi_araddr_in,
  input  wire logic                 axi_arvalid_in,
  output logic                      axi_arready_out,
  output logic [31:0]               axi_rdata_out,
  output logic [1:0]                axi_rresp_out,
  output logic                      axi_rvalid_out,
  input  wire logic                 axi_rready_in,
  // Operand reads (data one cycle later)
  input  wire logic [1:0][3:0]      rd_idx_in,
  input  wire logic [1:0]           rd_hi_in,
  output logic [1:0][31:0]          rd_data_out,
  // General write
  input  wire logic                 wr_en_in,
  input  wire logic [3:0]           wr_idx_in,
  input  wire logic                 wr_hi_in,
  input  wire logic [31:0]          wr_data_in,
  // Branch-with-link and exceptions
  input  wire logic                 branch_with_link_in,
  input  wire logic                 exc_en_in,
  input  wire logic [4:0]           exc_mode_in,
  input  wire logic [31:0]          exc_link_in,
  input  wire logic                 exc_ret_in,
  // Status updates
  input  wire logic                 psr_wr_en_in,
  input  wire logic [31:0]          psr_wr_data_in,
  input  wire logic                 flag_we_in,
  input  wire logic [3:0]           flag_nzcv_in,
  // Condition check
  input  wire logic [3:0]           cond_in,
  input  wire logic                 is_branch_in,
  output logic                      cond_pass_out,
  // State view
  output logic [31:0]               pc_out,
  output logic [31:0]               current_status_reg_out,
  output logic [31:0]               saved_status_reg_out
);
  import rfb_pkg::*;

  // Elaboration guard: the decoder needs at least the low nibble of the address
  if (ADDR_W < 4) begin : g_addr_chk
    $error("ADDR_W too small for the register map");
  end

  logic [31:0] regs [RFB_NSLOT];
  logic [31:0] saved [4];
  logic [31:0] current_status_reg, next_current_status_reg;
  logic [12:0] dbg_sel;
  logic [4:0]  mode;
  logic        compact, priv, exc_ok;
  logic [4:0][4:0] lk_mode, lk_slot;
  logic [4:0][3:0] lk_idx;
  logic [31:0] pc_plus, next_pc;
  logic        wr_ok;

  assign mode = current_status_reg[4:0];
  assign compact = current_status_reg[RFB_PSR_T];
  assign priv = mode != RFB_MODE_USR;
  assign exc_ok = exc_en_in && rfb_has_saved(exc_mode_in);
  assign pc_plus = regs[15] + (compact ? RFB_LINK_OFS_CMP : RFB_LINK_OFS_WIDE);
  // Compact writes to 8..12 need the upper-move form; 13..15 are stack, link, pc
  assign wr_ok = wr_en_in && !(compact && !wr_hi_in && wr_idx_in >= RFB_IDX_HI
                               && wr_idx_in < RFB_IDX_SP);

  // Lookups: two reads, write, exception link, debug
  always_comb begin
    lk_mode = {mode, exc_mode_in, mode, mode, mode};
    lk_idx  = {4'h0, RFB_IDX_LR, RFB_IDX_LR, wr_idx_in, 4'h0};
    lk_mode[0] = dbg_sel[12:8];
    lk_idx[0]  = dbg_sel[3:0];
    lk_mode[4] = mode;
    lk_idx[4]  = rd_idx_in[1];
    lk_idx[3]  = rd_idx_in[0];
    lk_mode[3] = mode;
    lk_idx[2]  = wr_idx_in;
    lk_mode[2] = mode;
    lk_idx[1]  = RFB_IDX_LR;
    lk_mode[1] = exc_mode_in;
  end
  // Link for branch-with-link has its own slot mux, apart from the lookup path
  logic [4:0] link_slot;
  assign link_slot = (mode == RFB_MODE_FIQ) ? RFB_SLOT_FIQ + 5'h06 :
                     (mode == RFB_MODE_SVC) ? RFB_SLOT_SVC + 5'h01 :
                     (mode == RFB_MODE_IRQ) ? RFB_SLOT_IRQ + 5'h01 :
                     (mode == RFB_MODE_UND) ? RFB_SLOT_UND + 5'h01 : 5'h0E;

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_map
      rfb_bank_map u_map (
        .mode_in  (lk_mode[g]),
        .idx_in   (lk_idx[g]),
        .slot_out (lk_slot[g])
      );
    end
  endgenerate

  // Next status: exception beats return beats software beats flags
  always_comb begin
    next_current_status_reg = current_status_reg;
    if (exc_ok) begin
      next_current_status_reg[4:0] = exc_mode_in;
      next_current_status_reg[RFB_PSR_T] = 1'b0;
      next_current_status_reg[RFB_PSR_I] = 1'b1;
      if (exc_mode_in == RFB_MODE_FIQ) next_current_status_reg[RFB_PSR_F] = 1'b1;
    // A saved word never filled since reset holds no legal mode, so it is not restored
    end else if (exc_ret_in && rfb_has_saved(mode) && rfb_legal(saved[rfb_saved_idx(mode)][4:0])) begin
      next_current_status_reg = saved[rfb_saved_idx(mode)];
    end else if (psr_wr_en_in) begin
      next_current_status_reg[RFB_PSR_N:RFB_PSR_V] = psr_wr_data_in[RFB_PSR_N:RFB_PSR_V];
      // Illegal mode codes would wedge the core, so they are refused
      if (priv && rfb_legal(psr_wr_data_in[4:0])) next_current_status_reg[7:0] = psr_wr_data_in[7:0];
    end else if (flag_we_in) begin
      next_current_status_reg[RFB_PSR_N:RFB_PSR_V] = flag_nzcv_in;
    end
  end

  // Current status register
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      current_status_reg <= RFB_PSR_RESET;
    end else begin
      current_status_reg <= next_current_status_reg;
    end
  end

  // Saved status registers, one per exception mode
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) saved[i] <= 32'h00000000;
    end else if (exc_ok) begin
      saved[rfb_saved_idx(exc_mode_in)] <= current_status_reg;
    end
  end

  // Program counter value after this cycle, aligned to the next state
  always_comb begin
    next_pc = regs[15];
    if (wr_ok && lk_slot[2] == 5'h0F) next_pc = wr_data_in;
    next_pc[0] = 1'b0;
    if (!next_current_status_reg[RFB_PSR_T]) next_pc[1] = 1'b0;
  end

  // Storage slots: exception link beats branch link beats general write
  generate
    for (g = 0; g < RFB_NSLOT; g++) begin : g_slot
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          regs[g] <= 32'h00000000;
        end else if (g == 15) begin
          regs[g] <= next_pc;
        end else if (exc_ok && lk_slot[1] == 5'(g)) begin
          regs[g] <= exc_link_in;
        end else if (branch_with_link_in && !exc_ok && link_slot == 5'(g)) begin
          regs[g] <= pc_plus;
        end else if (wr_ok && lk_slot[2] == 5'(g)) begin
          regs[g] <= wr_data_in;
        end
      end
    end
  endgenerate

  // Operand reads; compact upper reads need the hi form
  generate
    for (g = 0; g < 2; g++) begin : g_rd
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          rd_data_out[g] <= 32'h00000000;
        end else if (compact && !rd_hi_in[g] && rd_idx_in[g] >= RFB_IDX_HI
                     && rd_idx_in[g] < RFB_IDX_SP) begin
          rd_data_out[g] <= 32'h00000000;
        end else begin
          rd_data_out[g] <= regs[lk_slot[3+g]];
        end
      end
    end
  endgenerate

  rfb_cond u_cond (
    .cond_in      (cond_in),
    .nzcv_in      (current_status_reg[RFB_PSR_N:RFB_PSR_V]),
    .compact_in   (compact),
    .is_branch_in (is_branch_in),
    .pass_out     (cond_pass_out)
  );

  assign pc_out = regs[15];
  assign current_status_reg_out = current_status_reg;
  assign saved_status_reg_out = rfb_has_saved(mode) ? saved[rfb_saved_idx(mode)] : 32'h00000000;

  // AXI write side: address and data held until both arrive
  logic        aw_have, w_have;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  assign axi_awready_out = !aw_have && !axi_bvalid_out;
  assign axi_wready_out  = !w_have && !axi_bvalid_out;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      axi_bvalid_out <= 1'b0;
      axi_bresp_out <= RFB_RESP_OK;
      dbg_sel <= {RFB_MODE_USR, 8'h00};
    end else begin
      if (axi_awvalid_in && axi_awready_out) begin
        aw_have <= 1'b1;
        aw_addr <= 8'(axi_awaddr_in);
      end
      if (axi_wvalid_in && axi_wready_out) begin
        w_have <= 1'b1;
        w_data <= axi_wdata_in;
        w_strb <= axi_wstrb_in;
      end
      if (aw_have && w_have) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        axi_bvalid_out <= 1'b1;
        // Only the selector is writable; state views are read-only
        if (aw_addr == RFB_OFS_SEL) begin
          axi_bresp_out <= RFB_RESP_OK;
          if (w_strb[0]) dbg_sel[3:0] <= w_data[3:0];
          if (w_strb[1]) dbg_sel[12:8] <= w_data[12:8];
        end else begin
          axi_bresp_out <= RFB_RESP_ERR;
        end
      end else if (axi_bvalid_out && axi_bready_in) begin
        axi_bvalid_out <= 1'b0;
      end
    end
  end

  // AXI read side: one outstanding read, answered next cycle
  assign axi_arready_out = !axi_rvalid_out;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      axi_rvalid_out <= 1'b0;
      axi_rdata_out <= 32'h00000000;
      axi_rresp_out <= RFB_RESP_OK;
    end else if (axi_arvalid_in && axi_arready_out) begin
      axi_rvalid_out <= 1'b1;
      axi_rresp_out <= RFB_RESP_OK;
      if (8'(axi_araddr_in) == RFB_OFS_SEL) begin
        axi_rdata_out <= {19'h0, dbg_sel};
      end else if (8'(axi_araddr_in) == RFB_OFS_DATA) begin
        axi_rdata_out <= regs[lk_slot[0]];
      end else if (8'(axi_araddr_in) == RFB_OFS_PSR) begin
        axi_rdata_out <= current_status_reg;
      end else if (8'(axi_araddr_in) == RFB_OFS_SAVED) begin
        axi_rdata_out <= rfb_has_saved(dbg_sel[12:8]) ? saved[rfb_saved_idx(dbg_sel[12:8])] : 32'h00000000;
      end else begin
        axi_rdata_out <= 32'h00000000;
        axi_rresp_out <= RFB_RESP_ERR;
      end
    end else if (axi_rvalid_out && axi_rready_in) begin
      axi_rvalid_out <= 1'b0;
    end
  end

  // Checks
  sequence s_exc_taken;
    exc_en_in && rfb_has_saved(exc_mode_in);
  endsequence
  sequence s_entry_done;
    ##1 (current_status_reg[4:0] == $past(exc_mode_in)) && !current_status_reg[RFB_PSR_T] && current_status_reg[RFB_PSR_I];
  endsequence

  property p_pc_align;
    @(posedge ref_clk_in) disable iff (rst_in)
      !regs[15][0] && (current_status_reg[RFB_PSR_T] || !regs[15][1]);
  endproperty
  a_pc_align: assert property (p_pc_align) else $error("pc alignment broken");

  property p_exc_entry;
    @(posedge ref_clk_in) disable iff (rst_in) s_exc_taken |-> s_entry_done;
  endproperty
  a_exc_entry: assert property (p_exc_entry) else $error("exception entry mode wrong");

  property p_exc_saved;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_exc_taken |=> saved[rfb_saved_idx($past(exc_mode_in))] == $past(current_status_reg);
  endproperty
  a_exc_saved: assert property (p_exc_saved) else $error("saved status not captured");

  property p_exc_link;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_exc_taken |=> regs[$past(lk_slot[1])] == $past(exc_link_in);
  endproperty
  a_exc_link: assert property (p_exc_link) else $error("exception link not written");

  property p_bl_user;
    @(posedge ref_clk_in) disable iff (rst_in)
      branch_with_link_in && !exc_en_in && (mode == RFB_MODE_USR || mode == RFB_MODE_SYS)
      |=> regs[14] == $past(pc_plus);
  endproperty
  a_bl_user: assert property (p_bl_user) else $error("link copy missing");

  property p_fiq_private;
    @(posedge ref_clk_in) disable iff (rst_in)
      wr_en_in && mode == RFB_MODE_FIQ && wr_idx_in == 4'h9 |=> $stable(regs[9]);
  endproperty
  a_fiq_private: assert property (p_fiq_private) else $error("fast bank leaked to shared");

  property p_user_ctrl;
    @(posedge ref_clk_in) disable iff (rst_in)
      psr_wr_en_in && !priv && !exc_en_in && !exc_ret_in |=> current_status_reg[7:0] == $past(current_status_reg[7:0]);
  endproperty
  a_user_ctrl: assert property (p_user_ctrl) else $error("user changed control bits");

  property p_mode_legal;
    @(posedge ref_clk_in) disable iff (rst_in) rfb_legal(current_status_reg[4:0]);
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal mode reached");

  property p_hi_block;
    @(posedge ref_clk_in) disable iff (rst_in)
      compact && !rd_hi_in[0] && rd_idx_in[0] == 4'hA |=> rd_data_out[0] == 32'h00000000;
  endproperty
  a_hi_block: assert property (p_hi_block) else $error("compact upper read not blocked");

  property p_low_shared;
    @(posedge ref_clk_in) disable iff (rst_in)
      rd_idx_in[1] < RFB_IDX_HI |=> rd_data_out[1] == $past(regs[rd_idx_in[1]]);
  endproperty
  a_low_shared: assert property (p_low_shared) else $error("low register not shared");

  property p_compact_cond;
    @(posedge ref_clk_in) disable iff (rst_in) compact && !is_branch_in |-> cond_pass_out;
  endproperty
  a_compact_cond: assert property (p_compact_cond) else $error("compact non-branch conditional");
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the banked register file.
// Assumes rfb_pkg and rfb_core are compiled first; one clock, 25 MHz.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rfb_pkg::*;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, ib = 1'b0, cc = 1'b0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wdat = '0, A, B, C, D, L, P, Q;
  logic [3:0] cnd = '0;
  wire logic awr, wrd, bv, arr, rv, cp, mk, rh, we, bl, xe, xr, pe, fe;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdat, wd, xl, pd, pco, csr, ssr;
  wire logic [1:0][31:0] rdo;
  wire logic [3:0] ri, wi, fn;
  wire logic [4:0] xm;
  logic mk_d = 1'b0;
  logic [31:0] exp_q[$];
  int fails = 0, checks = 0, cyc = 0;

  // Bench clock, 40 ns period
  initial forever #20 clk = ~clk;

  rfb_regfile rfb_regfile_inst (.ref_clk_in(clk), .rst_in(rst), .axi_awaddr_in(awa), .axi_awvalid_in(awv),
    .axi_awready_out(awr), .axi_wdata_in(wdat), .axi_wstrb_in(4'hF), .axi_wvalid_in(wv), .axi_wready_out(wrd),
    .axi_bresp_out(bresp), .axi_bvalid_out(bv), .axi_bready_in(br), .axi_araddr_in(ara), .axi_arvalid_in(arv),
    .axi_arready_out(arr), .axi_rdata_out(rdat), .axi_rresp_out(rresp), .axi_rvalid_out(rv), .axi_rready_in(rr),
    .rd_idx_in({ri, ri}), .rd_hi_in({rh, rh}), .rd_data_out(rdo), .wr_en_in(we), .wr_idx_in(wi), .wr_hi_in(rh),
    .wr_data_in(wd), .branch_with_link_in(bl), .exc_en_in(xe), .exc_mode_in(xm), .exc_link_in(xl),
    .exc_ret_in(xr), .psr_wr_en_in(pe), .psr_wr_data_in(pd), .flag_we_in(fe), .flag_nzcv_in(fn),
    .cond_in(cnd), .is_branch_in(ib), .cond_pass_out(cp), .pc_out(pco), .current_status_reg_out(csr),
    .saved_status_reg_out(ssr));
  rfb_core rfb_core_inst (.clk_in(clk), .ri_out(ri), .rh_out(rh), .mk_out(mk), .we_out(we), .wi_out(wi),
    .wd_out(wd), .bl_out(bl), .xe_out(xe), .xm_out(xm), .xl_out(xl), .xr_out(xr), .pe_out(pe), .pd_out(pd),
    .fe_out(fe), .fn_out(fn));

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watcher: pops the oldest note whenever a result shows; also cuts a hang short
  always @(posedge clk) begin
    mk_d <= mk;
    if (mk_d) begin
      cmp("rd_data0", exp_q.pop_front(), rdo[0]);
      cmp("rd_data1", exp_q.pop_front(), rdo[1]);
      if (ri == RFB_IDX_PC) cmp("pc", exp_q.pop_front(), pco);
    end
    if (bv && br) cmp("bresp", exp_q.pop_front(), {30'h0, bresp});
    if (rv && rr) begin
      cmp("rdata", exp_q.pop_front(), rdat);
      cmp("rresp", exp_q.pop_front(), {30'h0, rresp});
      if (ara == RFB_OFS_PSR) cmp("status", exp_q.pop_front(), csr);
      if (ara == RFB_OFS_SAVED) cmp("saved", exp_q.pop_front(), ssr);
    end
    // Verdict strobe: inputs were set one edge earlier, so the output has settled
    if (cc) cmp("cond_pass", exp_q.pop_front(), {31'h0, cp});
    cyc++;
    if (cyc > 5000) begin
      fails++;
      final_report;
    end
  end

  task automatic op(input int k, input logic [3:0] i, input logic [31:0] d, input logic [4:0] m);
    rfb_core_inst.pulse(k, i, d, m);
  endtask

  // Operand read; data is expected one cycle after the index
  task automatic rd(input logic [3:0] i, input logic h, input logic [31:0] e);
    exp_q.push_back(e);
    exp_q.push_back(e);
    if (i == RFB_IDX_PC) exp_q.push_back(e);
    op(0, i, 32'h0, {4'h0, h});
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({30'h0, r});
    @(posedge clk);
    awa <= a; wdat <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back(d);
    exp_q.push_back({30'h0, r});
    if (a == RFB_OFS_PSR || a == RFB_OFS_SAVED) exp_q.push_back(d);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
  endtask

  // Condition verdict is combinational; the watcher looks one edge after the inputs change
  task automatic chkc(input logic [3:0] c, input logic b, input logic e);
    exp_q.push_back({31'h0, e});
    @(posedge clk);
    cnd <= c; ib <= b; cc <= 1'b1;
    @(posedge clk);
    cc <= 1'b0;
  endtask

  initial begin
    void'($urandom(32'hDAFF));
    A = $urandom; B = $urandom; C = $urandom; D = $urandom; L = $urandom; P = $urandom; Q = $urandom;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    axr(RFB_OFS_SEL, 32'h00001000, RFB_RESP_OK);
    axr(RFB_OFS_PSR, RFB_PSR_RESET, RFB_RESP_OK);
    axr(8'h10, 32'h0, RFB_RESP_ERR);
    axw(RFB_OFS_DATA, A, RFB_RESP_ERR);
    op(1, 4'h8, A, 5'h0);
    op(1, 4'hD, B, 5'h0);
    op(1, 4'h0, C, 5'h0);
    op(5, 4'h0, 32'h000000D1, 5'h0);
    op(1, 4'h8, D, 5'h0);
    rd(4'h8, 1'b0, D);
    rd(4'hD, 1'b0, 32'h0);
    axw(RFB_OFS_SEL, 32'h00001008, RFB_RESP_OK);
    axr(RFB_OFS_DATA, A, RFB_RESP_OK);
    op(5, 4'h0, 32'h000000D0, 5'h0);
    rd(4'h8, 1'b0, A);
    rd(4'hD, 1'b0, 32'h0);
    op(5, 4'h0, 32'h000000D3, 5'h0);
    axr(RFB_OFS_PSR, 32'h000000D0, RFB_RESP_OK);
    op(3, 4'h0, L, RFB_MODE_IRQ);
    axr(RFB_OFS_PSR, 32'h000000D2, RFB_RESP_OK);
    axw(RFB_OFS_SEL, 32'h0000120E, RFB_RESP_OK);
    axr(RFB_OFS_DATA, L, RFB_RESP_OK);
    axr(RFB_OFS_SAVED, 32'h000000D0, RFB_RESP_OK);
    op(1, 4'hF, P | 32'h3, 5'h0);
    rd(4'hF, 1'b0, P & ~32'h3);
    op(2, 4'h0, 32'h0, 5'h0);
    rd(4'hE, 1'b0, (P & ~32'h3) + 32'h4);
    op(4, 4'h0, 32'h0, 5'h0);
    axr(RFB_OFS_PSR, 32'h000000D0, RFB_RESP_OK);
    rd(4'hE, 1'b0, 32'h0);
    op(3, 4'h0, L, RFB_MODE_SVC);
    op(5, 4'h0, 32'h000000DF, 5'h0);
    rd(4'hD, 1'b0, 32'h0);
    op(5, 4'h0, 32'h000000F3, 5'h0);
    op(1, 4'hF, Q | 32'h3, 5'h0);
    rd(4'hF, 1'b0, Q & ~32'h1);
    rd(4'h9, 1'b0, 32'h0);
    rd(4'h8, 1'b1, A);
    rd(4'h0, 1'b0, C);
    rd(4'hD, 1'b0, B);
    op(2, 4'h0, 32'h0, 5'h0);
    rd(4'hE, 1'b0, (Q & ~32'h1) + 32'h2);
    op(6, 4'h4, 32'h0, 5'h0);
    axr(RFB_OFS_PSR, 32'h400000F3, RFB_RESP_OK);
    chkc(4'h1, 1'b0, 1'b1);
    chkc(4'h1, 1'b1, 1'b0);
    chkc(4'h0, 1'b1, 1'b1);
    // Let the watcher take the last note before the verdict
    repeat (2) @(posedge clk);
    final_report;
  end
endmodule
`default_nettype wire
